// >>> hdl/decimal_edit_pattern_engine.v
// Purpose: executes one edit pattern operator per start write
// Assumes: memory port on pclk; mem_ack is the ready of a held request
// Notes: insert, adjust-input and end operators are reported as reserved
// Function
// - code 04 stores the sign character at the destination pointer and advances it
// - 8x stores the fill character low-nibble times to consecutive bytes
// - 9x fetches a digit per repeat; nonzero sets significance, clears zero
// - digit move stores fill while insignificant, else ascii zero plus digit
// - repeat count above remaining digits aborts instead of running
// - Ax: first nonzero digit without significance stores sign, sets significance
// - float stores digit characters once significant, fill before that
// - code 01 stores sign and sets significance only if significance clear
// - code 45 with zero set moves pointer back len and refills with fill
// - code 46 with zero set overwrites byte len before pointer, pointer kept
// - code 40 loads fill, code 41 loads sign from the operand byte
// - code 42 loads sign if positive, code 43 if negative flag set
// - code 02 clears significance, code 03 sets it
// - fill lives in char state bits 7:0, sign in bits 15:8
// - repeat operators are 81-8F, 91-9F, A1-AF with count in bits 3:0
// - digit fetch alternates high then low nibble, counts down, advances after low
//
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`include "edit_engine_consts.vh"
module decimal_edit_pattern_engine #(
  parameter AW = 32,
  parameter CW = 16
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  // byte memory port
  output wire mem_req,
  output wire mem_we,
  output wire [AW-1:0] mem_addr,
  output wire [7:0] mem_wdata,
  input wire [7:0] mem_rdata,
  input wire mem_ack,
  // interrupt
  output wire irq
);
  localparam [1:0] S_IDLE = 2'd0, S_EXEC = 2'd1, S_FETCH = 2'd2, S_WRITE = 2'd3;
  localparam [1:0] M_ONCE = 2'd0, M_PAD = 2'd1, M_DIGITS = 2'd2, M_PATCH = 2'd3;

  function [7:0] digit_char;
    input [3:0] d;
    begin
      digit_char = `ASCII_ZERO + {4'h0, d};
    end
  endfunction

  reg [1:0] state_ff;
  reg [1:0] mode_ff;
  reg [7:0] op_ff;
  reg [7:0] arg_ff;
  reg [7:0] rep_ff;
  reg [15:0] char_ff;
  reg sig_ff;
  reg zero_ff;
  reg neg_ff;
  reg [AW-1:0] src_addr_ff;
  reg [CW-1:0] src_cnt_ff;
  reg [AW-1:0] dst_ff;
  reg [AW-1:0] addr_ff;
  reg [7:0] wdata_ff;
  reg pend_ff;
  reg [3:0] digit_ff;
  reg [2:0] irq_st_ff;
  reg [2:0] irq_mask_ff;

  wire [7:0] fill = char_ff[7:0];
  wire [7:0] sign = char_ff[15:8];
  wire [3:0] op_hi = op_ff[7:4];
  wire [3:0] op_cnt = op_ff[3:0];
  wire is_float = (op_hi == `OPH_COPY_FLOAT);

  // apb decode
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire idle = (state_ff == S_IDLE);
  wire known = (paddr == `OFS_OPERATOR) || (paddr == `OFS_STATUS) ||
    (paddr == `OFS_FLAGS) || (paddr == `OFS_CHAR_STATE) ||
    (paddr == `OFS_SRC_ADDR) || (paddr == `OFS_SRC_COUNT) ||
    (paddr == `OFS_DEST_PTR) || (paddr == `OFS_IRQ_STATUS) ||
    (paddr == `OFS_IRQ_MASK);
  // context writes are ignored mid-operator so the datapath never sees a torn state
  wire start = wr && idle && (paddr == `OFS_OPERATOR);
  wire ctx_wr = wr && idle;
  assign pready = 1'b1;

  // digit fetch
  wire [3:0] fetched;
  wire [AW-1:0] nxt_src_addr;
  wire [CW-1:0] nxt_src_cnt;
  digit_step #(.AW(AW), .CW(CW)) u_step (
    .src_addr(src_addr_ff),
    .src_count(src_cnt_ff),
    .src_byte(mem_rdata),
    .digit(fetched),
    .nxt_src_addr(nxt_src_addr),
    .nxt_src_count(nxt_src_cnt)
  );

  assign mem_req = (state_ff == S_FETCH) || (state_ff == S_WRITE);
  assign mem_we = (state_ff == S_WRITE);
  assign mem_addr = addr_ff;
  assign mem_wdata = wdata_ff;

  wire nz = (fetched != 4'h0);
  wire [7:0] nxt_rep = rep_ff - 8'h01;
  wire [CW-1:0] rep_wide = {{(CW-4){1'b0}}, op_cnt};
  reg done_evt, abort_evt, rsv_evt;

  // operator datapath
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= S_IDLE;
      mode_ff <= M_ONCE;
      op_ff <= 8'h00;
      arg_ff <= 8'h00;
      rep_ff <= 8'h00;
      char_ff <= {`RST_SIGN, `RST_FILL};
      sig_ff <= 1'b0;
      zero_ff <= 1'b0;
      neg_ff <= 1'b0;
      src_addr_ff <= {AW{1'b0}};
      src_cnt_ff <= {CW{1'b0}};
      dst_ff <= {AW{1'b0}};
      addr_ff <= {AW{1'b0}};
      wdata_ff <= 8'h00;
      pend_ff <= 1'b0;
      digit_ff <= 4'h0;
      done_evt <= 1'b0;
      abort_evt <= 1'b0;
      rsv_evt <= 1'b0;
    end else begin
      done_evt <= 1'b0;
      abort_evt <= 1'b0;
      rsv_evt <= 1'b0;
      case (state_ff)
        S_IDLE: begin
          if (start) begin
            op_ff <= pwdata[7:0];
            arg_ff <= pwdata[15:8];
            state_ff <= S_EXEC;
          end else if (ctx_wr) begin
            if (paddr == `OFS_FLAGS) begin
              sig_ff <= pwdata[`FLAG_SIGNIF];
              zero_ff <= pwdata[`FLAG_ZERO];
              neg_ff <= pwdata[`FLAG_NEG];
            end
            if (paddr == `OFS_CHAR_STATE)
              char_ff <= pwdata[15:0];
            if (paddr == `OFS_SRC_ADDR)
              src_addr_ff <= pwdata[AW-1:0];
            if (paddr == `OFS_SRC_COUNT)
              src_cnt_ff <= pwdata[CW-1:0];
            if (paddr == `OFS_DEST_PTR)
              dst_ff <= pwdata[AW-1:0];
          end
        end
        S_EXEC: begin
          state_ff <= S_IDLE;
          done_evt <= 1'b1;
          addr_ff <= dst_ff;
          rep_ff <= 8'h01;
          mode_ff <= M_ONCE;
          case (op_ff)
            `OPC_PUT_SIGN: begin
              wdata_ff <= sign;
              state_ff <= S_WRITE;
              done_evt <= 1'b0;
            end
            `OPC_CLOSE_FLOAT: begin
              if (!sig_ff) begin
                wdata_ff <= sign;
                sig_ff <= 1'b1;
                state_ff <= S_WRITE;
                done_evt <= 1'b0;
              end
            end
            `OPC_DROP_SIGNIF: sig_ff <= 1'b0;
            `OPC_FORCE_SIGNIF: sig_ff <= 1'b1;
            `OPC_SET_PAD: char_ff[7:0] <= arg_ff;
            `OPC_SET_SIGN: char_ff[15:8] <= arg_ff;
            `OPC_SIGN_IF_POS: begin
              if (!neg_ff)
                char_ff[15:8] <= arg_ff;
            end
            `OPC_SIGN_IF_NEG: begin
              if (neg_ff)
                char_ff[15:8] <= arg_ff;
            end
            `OPC_BLANK_BACK: begin
              // a zero length is meaningless and is treated as no operation
              if (zero_ff && (arg_ff != 8'h00)) begin
                dst_ff <= dst_ff - {{(AW-8){1'b0}}, arg_ff};
                addr_ff <= dst_ff - {{(AW-8){1'b0}}, arg_ff};
                rep_ff <= arg_ff;
                wdata_ff <= fill;
                mode_ff <= M_PAD;
                state_ff <= S_WRITE;
                done_evt <= 1'b0;
              end
            end
            `OPC_PATCH_SIGN: begin
              if (zero_ff && (arg_ff != 8'h00)) begin
                addr_ff <= dst_ff - {{(AW-8){1'b0}}, arg_ff};
                wdata_ff <= fill;
                mode_ff <= M_PATCH;
                state_ff <= S_WRITE;
                done_evt <= 1'b0;
              end
            end
            default: begin
              done_evt <= 1'b0;
              if (op_cnt == 4'h0) begin
                rsv_evt <= 1'b1;
              end else if (op_hi == `OPH_PAD_REPEAT) begin
                rep_ff <= {4'h0, op_cnt};
                wdata_ff <= fill;
                mode_ff <= M_PAD;
                state_ff <= S_WRITE;
              end else if ((op_hi == `OPH_COPY) || is_float) begin
                if (rep_wide > src_cnt_ff) begin
                  abort_evt <= 1'b1;
                end else begin
                  rep_ff <= {4'h0, op_cnt};
                  mode_ff <= M_DIGITS;
                  addr_ff <= src_addr_ff;
                  state_ff <= S_FETCH;
                end
              end else begin
                rsv_evt <= 1'b1;
              end
            end
          endcase
        end
        S_FETCH: begin
          if (mem_ack) begin
            src_addr_ff <= nxt_src_addr;
            src_cnt_ff <= nxt_src_cnt;
            addr_ff <= dst_ff;
            digit_ff <= fetched;
            state_ff <= S_WRITE;
            if (is_float) begin
              if (nz && !sig_ff) begin
                wdata_ff <= sign;
                pend_ff <= 1'b1;
                sig_ff <= 1'b1;
                zero_ff <= 1'b0;
              end else begin
                wdata_ff <= sig_ff ? digit_char(fetched) : fill;
              end
            end else begin
              if (nz) begin
                sig_ff <= 1'b1;
                zero_ff <= 1'b0;
              end
              wdata_ff <= (sig_ff || nz) ? digit_char(fetched) : fill;
            end
          end
        end
        S_WRITE: begin
          if (mem_ack) begin
            if (mode_ff != M_PATCH)
              dst_ff <= dst_ff + {{(AW-1){1'b0}}, 1'b1};
            addr_ff <= dst_ff + {{(AW-1){1'b0}}, 1'b1};
            if (pend_ff) begin
              // sign went out first; the digit that made it significant follows
              pend_ff <= 1'b0;
              wdata_ff <= digit_char(digit_ff);
            end else if (nxt_rep == 8'h00) begin
              state_ff <= S_IDLE;
              done_evt <= 1'b1;
            end else begin
              rep_ff <= nxt_rep;
              if (mode_ff == M_DIGITS) begin
                addr_ff <= src_addr_ff;
                state_ff <= S_FETCH;
              end
            end
          end
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end

  // interrupt status: set wins over a write-one clear in the same cycle
  wire [2:0] evts = {rsv_evt, abort_evt, done_evt};
  wire [2:0] w1c = (wr && (paddr == `OFS_IRQ_STATUS)) ? pwdata[2:0] : 3'h0;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st_ff <= 3'h0;
      irq_mask_ff <= 3'h0;
    end else begin
      irq_st_ff <= (irq_st_ff & ~w1c) | evts;
      if (wr && (paddr == `OFS_IRQ_MASK))
        irq_mask_ff <= pwdata[2:0];
    end
  end
  assign irq = |(irq_st_ff & irq_mask_ff);

  // read data is captured in the setup cycle and presented in the access cycle
  reg [31:0] nxt_prdata;
  always @* begin
    nxt_prdata = 32'h0000_0000;
    case (paddr)
      `OFS_OPERATOR: nxt_prdata = {16'h0000, arg_ff, op_ff};
      `OFS_STATUS: nxt_prdata = {31'h0000_0000, !idle};
      `OFS_FLAGS: nxt_prdata = {29'h0000_0000, neg_ff, zero_ff, sig_ff};
      `OFS_CHAR_STATE: nxt_prdata = {16'h0000, char_ff};
      `OFS_SRC_ADDR: nxt_prdata[AW-1:0] = src_addr_ff;
      `OFS_SRC_COUNT: nxt_prdata[CW-1:0] = src_cnt_ff;
      `OFS_DEST_PTR: nxt_prdata[AW-1:0] = dst_ff;
      `OFS_IRQ_STATUS: nxt_prdata = {29'h0000_0000, irq_st_ff};
      `OFS_IRQ_MASK: nxt_prdata = {29'h0000_0000, irq_mask_ff};
      default: nxt_prdata = 32'h0000_0000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= pwrite ? 32'h0000_0000 : nxt_prdata;
      pslverr <= !known;
    end
  end
endmodule // decimal_edit_pattern_engine

// >>> hdl/digit_step.v
// Purpose: one source digit fetch step
// Assumes: count is the number of digits still to read, before this read
// Notes: pure combinational
`timescale 1ns/10ps
module digit_step #(
  parameter AW = 32,
  parameter CW = 16
) (
  // current source position
  input wire [AW-1:0] src_addr,
  input wire [CW-1:0] src_count,
  input wire [7:0] src_byte,
  // result
  output wire [3:0] digit,
  output wire [AW-1:0] nxt_src_addr,
  output wire [CW-1:0] nxt_src_count
);
  // odd count selects the high nibble, so digits come high then low
  assign digit = src_count[0] ? src_byte[7:4] : src_byte[3:0];
  assign nxt_src_count = src_count - {{(CW-1){1'b0}}, 1'b1};
  // the address moves on only once the low nibble has been consumed
  assign nxt_src_addr = nxt_src_count[0] ? src_addr + {{(AW-1){1'b0}}, 1'b1} : src_addr;
endmodule // digit_step

// >>> hdl/edit_engine_consts.vh
// Purpose: constants for the decimal edit pattern engine
// Assumes: byte-wide memory port, 32-bit apb data
// Notes: definitions only
`ifndef EDIT_ENGINE_CONSTS_VH
`define EDIT_ENGINE_CONSTS_VH

// register byte offsets
`define OFS_OPERATOR 8'h00
`define OFS_STATUS 8'h04
`define OFS_FLAGS 8'h08
`define OFS_CHAR_STATE 8'h0C
`define OFS_SRC_ADDR 8'h10
`define OFS_SRC_COUNT 8'h14
`define OFS_DEST_PTR 8'h18
`define OFS_IRQ_STATUS 8'h1C
`define OFS_IRQ_MASK 8'h20

// flag bit positions
`define FLAG_SIGNIF 0
`define FLAG_ZERO 1
`define FLAG_NEG 2

// irq status bit positions
`define IRQ_DONE 0
`define IRQ_ABORT 1
`define IRQ_RESERVED 2

// reset values: fill and sign are both a space
`define RST_FILL 8'h20
`define RST_SIGN 8'h20

// operator codes
`define OPC_CLOSE_FLOAT 8'h01
`define OPC_DROP_SIGNIF 8'h02
`define OPC_FORCE_SIGNIF 8'h03
`define OPC_PUT_SIGN 8'h04
`define OPC_SET_PAD 8'h40
`define OPC_SET_SIGN 8'h41
`define OPC_SIGN_IF_POS 8'h42
`define OPC_SIGN_IF_NEG 8'h43
`define OPC_BLANK_BACK 8'h45
`define OPC_PATCH_SIGN 8'h46
`define OPH_PAD_REPEAT 4'h8
`define OPH_COPY 4'h9
`define OPH_COPY_FLOAT 4'hA

// code of the character zero
`define ASCII_ZERO 8'h30

`endif

// >>> tb/decimal_edit_pattern_engine_test.sv
// Purpose: directed tests of the edit pattern operators
// Assumes: memory model holds source digits and destination bytes
// Notes: expectations worked out by hand from the operator behaviour
`timescale 1ns/10ps
`include "edit_engine_consts.vh"
module decimal_edit_pattern_engine_test;
  reg pclk, presetn, psel, penable, pwrite, slow, slverr;
  reg [7:0] paddr, exp_sign;
  reg [31:0] pwdata, rd;
  wire [31:0] prdata, mem_addr;
  wire pready, pslverr, mem_req, mem_we, mem_ack, irq;
  wire [7:0] mem_wdata, mem_rdata;
  integer errors, check_count, i;
  decimal_edit_pattern_engine dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .irq(irq));
  edit_mem_model mem_i (.pclk(pclk), .presetn(presetn), .slow(slow), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack));
  task finish_test;
    begin
      if (errors == 0 && check_count > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task check(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      slverr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task rd_chk(input [7:0] a, input [31:0] e);
    begin
      apb(1'b0, a, 32'h0);
      check(rd, e);
    end
  endtask
  task run_op(input [7:0] op, input [7:0] opd);
    begin
      apb(1'b1, `OFS_OPERATOR, {16'h0, opd, op});
      repeat (2) @(posedge pclk);
      apb(1'b0, `OFS_STATUS, 32'h0);
      while (rd[0] !== 1'b0) apb(1'b0, `OFS_STATUS, 32'h0);
    end
  endtask
  task mem4(input [7:0] a, input [31:0] e);
    begin
      check({mem_i.store_ff[a], mem_i.store_ff[a+8'h1], mem_i.store_ff[a+8'h2],
        mem_i.store_ff[a+8'h3]}, e);
    end
  endtask
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    errors = errors + 1;
    finish_test;
  end
  initial begin
    {presetn, psel, penable, pwrite, slow, slverr} = 6'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    errors = 0;
    check_count = 0;
    for (i = 0; i < 256; i = i + 1) mem_i.store_ff[i] = 8'h00;
    mem_i.store_ff[1] = 8'h01;
    mem_i.store_ff[2] = 8'h2C;
    mem_i.store_ff[4] = 8'h5C;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(`OFS_CHAR_STATE, {16'h0, `RST_SIGN, `RST_FILL});
    rd_chk(`OFS_IRQ_MASK, 32'h0);
    rd_chk(8'h40, 32'h0);
    check(slverr, 1'b1);
    run_op(`OPC_SET_PAD, 8'h2A);
    run_op(`OPC_SET_SIGN, 8'h2B);
    rd_chk(`OFS_CHAR_STATE, 32'h2B2A);
    apb(1'b1, `OFS_SRC_ADDR, 32'h1);
    apb(1'b1, `OFS_SRC_COUNT, 32'h3);
    apb(1'b1, `OFS_DEST_PTR, 32'h80);
    apb(1'b1, `OFS_FLAGS, 32'h2);
    run_op(8'h93, 8'h00);
    mem4(8'h80, 32'h2A313200);
    rd_chk(`OFS_DEST_PTR, 32'h83);
    rd_chk(`OFS_FLAGS, 32'h1);
    rd_chk(`OFS_SRC_ADDR, 32'h2);
    rd_chk(`OFS_IRQ_STATUS, 32'h1);
    apb(1'b1, `OFS_IRQ_MASK, 32'h3);
    check(irq, 1'b1);
    apb(1'b1, `OFS_IRQ_STATUS, 32'h1);
    check(irq, 1'b0);
    run_op(8'h91, 8'h00);
    rd_chk(`OFS_IRQ_STATUS, 32'h2);
    check(irq, 1'b1);
    rd_chk(`OFS_DEST_PTR, 32'h83);
    apb(1'b1, `OFS_IRQ_STATUS, 32'h7);
    apb(1'b1, `OFS_IRQ_MASK, 32'h0);
    slow <= 1'b1;
    apb(1'b1, `OFS_SRC_ADDR, 32'h3);
    apb(1'b1, `OFS_SRC_COUNT, 32'h3);
    apb(1'b1, `OFS_FLAGS, 32'h2);
    run_op(8'hA3, 8'h00);
    mem4(8'h83, 32'h2A2A2B35);
    rd_chk(`OFS_FLAGS, 32'h1);
    slow <= 1'b0;
    run_op(`OPC_CLOSE_FLOAT, 8'h00);
    rd_chk(`OFS_DEST_PTR, 32'h87);
    run_op(`OPC_DROP_SIGNIF, 8'h00);
    rd_chk(`OFS_FLAGS, 32'h0);
    run_op(`OPC_CLOSE_FLOAT, 8'h00);
    run_op(`OPC_PUT_SIGN, 8'h00);
    run_op(8'h82, 8'h00);
    mem4(8'h87, 32'h2B2B2A2A);
    rd_chk(`OFS_DEST_PTR, 32'h8B);
    run_op(`OPC_SET_PAD, 8'h5F);
    apb(1'b1, `OFS_FLAGS, 32'h3);
    run_op(`OPC_BLANK_BACK, 8'h03);
    mem4(8'h88, 32'h5F5F5F00);
    run_op(`OPC_PATCH_SIGN, 8'h05);
    mem4(8'h84, 32'h2A2B5F2B);
    apb(1'b1, `OFS_FLAGS, 32'h1);
    run_op(`OPC_BLANK_BACK, 8'h04);
    run_op(`OPC_PATCH_SIGN, 8'h04);
    mem4(8'h87, 32'h2B5F5F5F);
    rd_chk(`OFS_DEST_PTR, 32'h8B);
    exp_sign = 8'h2B;
    // sign loads only when the op's polarity matches the negative flag
    for (i = 0; i < 4; i = i + 1) begin
      apb(1'b1, `OFS_FLAGS, {29'h0, i[1], 2'h0});
      run_op(`OPC_SIGN_IF_POS + i[0], 8'h50 + i[7:0]);
      if (i[0] == i[1])
        exp_sign = 8'h50 + i[7:0];
      rd_chk(`OFS_CHAR_STATE, {16'h0, exp_sign, 8'h5F});
    end
    run_op(`OPC_FORCE_SIGNIF, 8'h00);
    rd_chk(`OFS_FLAGS, 32'h5);
    run_op(8'h80, 8'h00);
    rd_chk(`OFS_IRQ_STATUS, 32'h5);
    finish_test;
  end
endmodule // decimal_edit_pattern_engine_test

// >>> tb/edit_engine_assertions.sv
// Purpose: port-level checks for the edit pattern engine
// Assumes: zero wait state apb, memory ack sampled with request
// Notes: bound into the engine, sees only its ports
`timescale 1ns/10ps
`include "edit_engine_consts.vh"
module edit_engine_checker #(
  parameter AW = 32,
  parameter CW = 16
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // memory port
  input wire mem_req,
  input wire mem_we,
  input wire [AW-1:0] mem_addr,
  input wire [7:0] mem_wdata,
  input wire [7:0] mem_rdata,
  input wire mem_ack,
  // interrupt
  input wire irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_pready_high: assert property (pready) else $error("pready low");
  a_reset_quiet: assert property ($rose(presetn) |-> !mem_req && !irq)
    else $error("activity right after reset");
  // a held request must not move, or the far side would latch a torn transfer
  a_mem_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
    && $stable(mem_we) && $stable(mem_wdata)) else $error("memory request changed early");
  a_store_step: assert property (mem_req && mem_we && mem_ack ##1 mem_req && mem_we
    |-> mem_addr == $past(mem_addr) + 1) else $error("store not one byte on");
  a_read_store: assert property (mem_req && !mem_we && mem_ack |=> mem_req && mem_we)
    else $error("digit read not followed by store");
  a_unmapped_err: assert property (psel && !penable && paddr > `OFS_IRQ_MASK
    |=> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
  a_mapped_ok: assert property (psel && !penable && paddr <= `OFS_IRQ_MASK
    && paddr[1:0] == 2'h0 |=> !pslverr) else $error("mapped access refused");
  a_mask_clear: assert property (psel && penable && pwrite && paddr == `OFS_IRQ_MASK
    && pwdata[2:0] == 3'h0 |=> !irq) else $error("irq high with mask zero");
  c_read: cover property (mem_req && !mem_we && mem_ack);
  c_stall: cover property (mem_req && !mem_ack);
  c_irq: cover property ($rose(irq));
endmodule // edit_engine_checker

bind decimal_edit_pattern_engine edit_engine_checker #(.AW(AW), .CW(CW)) chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
  .mem_rdata(mem_rdata), .mem_ack(mem_ack), .irq(irq));

// >>> tb/edit_mem_model.sv
// Purpose: byte memory answering the engine's request port
// Assumes: 256 bytes, address low byte only
// Notes: slow mode acks every other cycle to stall the engine
`timescale 1ns/10ps
module edit_mem_model (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // pacing
  input wire slow,
  // memory port
  input wire mem_req,
  input wire mem_we,
  input wire [31:0] mem_addr,
  input wire [7:0] mem_wdata,
  output wire [7:0] mem_rdata,
  output wire mem_ack
);
  reg [7:0] store_ff [0:255];
  reg [7:0] last_ff;
  reg ph_ff;
  assign mem_ack = mem_req && (!slow || ph_ff);
  // outside an acked read the data lines show garbage, not a stale digit
  assign mem_rdata = (mem_ack && !mem_we) ? store_ff[mem_addr[7:0]] : ~last_ff;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_ff <= 1'b0;
      last_ff <= 8'h00;
    end else begin
      ph_ff <= ~ph_ff;
      if (mem_ack && mem_we) begin
        store_ff[mem_addr[7:0]] <= mem_wdata;
        last_ff <= mem_wdata;
      end else if (mem_ack) begin
        last_ff <= mem_rdata;
      end
    end
  end
endmodule // edit_mem_model
